// ---- pled_cfg.svh ----
/*
 * Timing counts and option defaults for the front-panel power LED patterns.
 * Assumes a 20 MHz system clock; all pattern times are whole quarter seconds.
 */
// Function
// - working state: LED solid on in primary color, no blinking.
// - working indication on after reset; a setting can turn it off.
// - standby: alternate color 0.25 s on, 0.25 s off, repeating.
// - standby blink is default; a setting replaces it with another indication.
// - low-power ready mode: primary color 1 s on, 1 s off, repeating.
// - firmware update: off first, then 0.5 s on / 0.5 s off until done.
// - memory error: three 1 s on/off cycles, 2.5 s off, repeat forever.
// - thermal trip: primary color 0.25 s on, 0.25 s off.
// - thermal trip stops after exactly 16 blinks, 8 seconds total.
// - recoverable self-test error shows its error pattern on the LED.
`ifndef PLED_CFG_SVH
`define PLED_CFG_SVH

`define PLED_CLK_HZ        20000000
`define PLED_TICK_MS       250
`define PLED_TICK_CYC      ((`PLED_CLK_HZ / 1000) * `PLED_TICK_MS)
`define PLED_STBY_PH       8'h01
`define PLED_READY_PH      8'h04
`define PLED_FWUP_PH       8'h02
`define PLED_MEM_PH        8'h04
`define PLED_MEM_PAUSE     8'h0A
`define PLED_MEM_BLINKS    8'h03
`define PLED_THERM_PH      8'h01
`define PLED_THERM_BLINKS  8'h10
`define PLED_WORK_EN_RST   1'b1
`define PLED_STBY_ALT_RST  1'b0

`endif

// ---- pled_pkg.sv ----
/*
 * Types for the power LED pattern generator.
 * Assumes pled_cfg.svh is included by the modules that need the counts.
 */
package pled_pkg;

    typedef enum logic [2:0] {
        PLED_OFF   = 3'h0,
        PLED_WORK  = 3'h1,
        PLED_STBY  = 3'h3,
        PLED_READY = 3'h2,
        PLED_FWUP  = 3'h6,
        PLED_THERM = 3'h7,
        PLED_MEM   = 3'h5
    } pled_pat_t;

    typedef struct packed {
        logic working;
        logic standby;
        logic ready_mode;
        logic fw_update;
        logic mem_error;
        logic therm_trip;
    } pled_req_t;

    typedef struct packed {
        logic primary;
        logic alternate;
    } pled_led_t;

endpackage

// ---- pled_tick.sv ----
/*
 * Quarter-second tick divider.
 * Assumes the 20 MHz clk_sys; restart realigns the tick phase to zero.
 */
`timescale 1ns/1ps
`include "pled_cfg.svh"

module pled_tick
    import pled_pkg::*;
(
    // clock and reset
    input  wire logic clk_sys,
    input  wire logic rst,
    // control
    input  wire logic restart,
    output logic      tick
);

    typedef struct packed {
        logic [22:0] cnt;
        logic        tick;
    } pled_tick_st_t;

    pled_tick_st_t st;
    pled_tick_st_t next_st;

    always_comb
    begin
        next_st = st;
        next_st.tick = 1'b0;
        if (restart)
        begin
            next_st.cnt = 23'h000000;
        end
        else if (st.cnt == 23'(`PLED_TICK_CYC - 1))
        begin
            next_st.cnt = 23'h000000;
            next_st.tick = 1'b1;
        end
        else
        begin
            next_st.cnt = st.cnt + 23'h000001;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            st <= '0;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign tick = st.tick;

endmodule

// ---- pled_top.sv ----
/*
 * Front-panel power LED pattern generator: picks the highest-priority
 * request and drives a two-color LED with its blink pattern.
 * Assumes request and setting inputs come from logic on clk_sys.
 */
`timescale 1ns/1ps
`include "pled_cfg.svh"

module pled_top
    import pled_pkg::*;
(
    // clock and reset
    input  wire logic      clk_sys,
    input  wire logic      rst,
    // state and condition requests
    input  wire pled_req_t req,
    input  wire logic      post_err,
    // settings
    input  wire logic      work_disable,
    input  wire logic      stby_alt_sel,
    // led
    output pled_led_t      led
);

    typedef struct packed {
        pled_pat_t pat;
        logic      work_en;
        logic      stby_alt;
        logic      therm_done;
        logic [7:0] phase_cnt;
        logic [7:0] blinks;
        logic      on;
        logic      pause;
        pled_led_t led;
    } pled_st_t;

    pled_st_t  st;
    pled_st_t  next_st;
    pled_pat_t sel;
    logic      tick;
    logic      restart;

    always_comb
    begin
        if (req.mem_error || post_err)
        begin
            sel = PLED_MEM;
        end
        // therm_done keeps a finished warning from being picked again
        else if (req.therm_trip && !st.therm_done)
        begin
            sel = PLED_THERM;
        end
        else if (req.fw_update)
        begin
            sel = PLED_FWUP;
        end
        else if (req.working)
        begin
            sel = PLED_WORK;
        end
        else if (req.standby)
        begin
            sel = PLED_STBY;
        end
        else if (req.ready_mode)
        begin
            sel = PLED_READY;
        end
        else
        begin
            sel = PLED_OFF;
        end
    end

    assign restart = (sel != st.pat);

    pled_tick u_tick (
        .clk_sys (clk_sys),
        .rst     (rst),
        .restart (restart),
        .tick    (tick)
    );

    function automatic logic [7:0] ph_len(input pled_pat_t p);
        unique case (p)
            PLED_STBY:  ph_len = `PLED_STBY_PH;
            PLED_READY: ph_len = `PLED_READY_PH;
            PLED_FWUP:  ph_len = `PLED_FWUP_PH;
            PLED_MEM:   ph_len = `PLED_MEM_PH;
            PLED_THERM: ph_len = `PLED_THERM_PH;
            default:    ph_len = 8'h01;
        endcase
    endfunction

    // every phase, pause included, ends on the count before its length
    function automatic logic last_step(input logic [7:0] cnt, input logic [7:0] len);
        last_step = (cnt == len - 8'h01);
    endfunction

    // shared by the phase and blink counters
    function automatic logic [7:0] bump(input logic [7:0] cnt);
        bump = cnt + 8'h01;
    endfunction

    // led levels for a state; dark phases and a finished warning show nothing
    function automatic pled_led_t led_of(input pled_st_t s);
        led_of = '0;
        unique case (s.pat)
            PLED_OFF:
            begin
                led_of = '0;
            end
            PLED_WORK:
            begin
                led_of.primary = s.work_en;
            end
            PLED_STBY:
            begin
                // alternate indication: steady alternate color
                if (s.stby_alt)
                    led_of.alternate = 1'b1;
                else
                    led_of.alternate = s.on;
            end
            PLED_READY:
            begin
                led_of.primary = s.on;
            end
            PLED_FWUP:
            begin
                led_of.primary = s.on;
            end
            PLED_MEM:
            begin
                led_of.primary = s.on && !s.pause;
            end
            PLED_THERM:
            begin
                led_of.primary = s.on && !s.therm_done;
            end
            default:
            begin
                led_of = '0;
            end
        endcase
    endfunction

    always_comb
    begin
        next_st = st;
        next_st.work_en = !work_disable;
        next_st.stby_alt = stby_alt_sel;
        if (!req.therm_trip)
            next_st.therm_done = 1'b0;
        // a pattern change wins over a tick landing in the same cycle
        if (restart)
        begin
            next_st.pat = sel;
            next_st.phase_cnt = 8'h00;
            next_st.blinks = 8'h00;
            next_st.pause = 1'b0;
            // update starts dark; others start lit
            next_st.on = (sel != PLED_FWUP);
        end
        else if (tick)
        begin
            if (st.pause)
            begin
                // pause counts ticks like a phase, with its own length
                if (last_step(st.phase_cnt, `PLED_MEM_PAUSE))
                begin
                    next_st.pause = 1'b0;
                    next_st.on = 1'b1;
                    next_st.phase_cnt = 8'h00;
                end
                else
                    next_st.phase_cnt = bump(st.phase_cnt);
            end
            else if (last_step(st.phase_cnt, ph_len(st.pat)))
            begin
                next_st.phase_cnt = 8'h00;
                next_st.on = !st.on;
                if (!st.on)
                begin
                    next_st.blinks = bump(st.blinks);
                    if (st.pat == PLED_MEM && last_step(st.blinks, `PLED_MEM_BLINKS))
                    begin
                        next_st.blinks = 8'h00;
                        next_st.pause = 1'b1;
                        next_st.on = 1'b0;
                    end
                    // warning ends dark; it is not picked again until the request drops
                    if (st.pat == PLED_THERM && last_step(st.blinks, `PLED_THERM_BLINKS))
                        next_st.therm_done = 1'b1;
                end
            end
            else
                next_st.phase_cnt = bump(st.phase_cnt);
        end
        // led drive from the state just computed, so it lands with the pattern
        next_st.led = led_of(next_st);
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            st <= '0;
            st.pat <= PLED_OFF;
            st.work_en <= `PLED_WORK_EN_RST;
            st.stby_alt <= `PLED_STBY_ALT_RST;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign led = st.led;

endmodule

// ---- pled_top_sva.sv ----
/* pled_top_sva: first-phase led levels per selected pattern.
   assumes a bind onto pled_top ports. */
`timescale 1ns/1ps
module pled_top_sva
    import pled_pkg::*;
(
    // clock and reset
    input wire logic      clk_sys,
    input wire logic      rst,
    // requests, settings, led
    input wire pled_req_t req,
    input wire logic      post_err,
    input wire logic      work_disable,
    input wire logic      stby_alt_sel,
    input wire pled_led_t led
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    logic err;
    logic hi;
    assign err = req.mem_error | post_err;
    assign hi = err | req.therm_trip | req.fw_update;
    // only first-phase levels: later phases sit beyond the 0.25 s tick
    sequence s_held;
        $stable({req, post_err, work_disable, stby_alt_sel})[*3];
    endsequence
    a_mem_first: assert property (s_held ##0 req.mem_error |-> led == 2'h2)
        else $error("memory error led wrong");
    a_post_err: assert property (s_held ##0 post_err |-> led == 2'h2)
        else $error("self-test error led wrong");
    a_therm_on: assert property (s_held ##0 (!err && req.therm_trip) |-> led == 2'h2)
        else $error("thermal led wrong");
    a_fwup_dark: assert property (s_held ##0 (!err && !req.therm_trip && req.fw_update)
        |-> led == 2'h0)
        else $error("update led not dark");
    a_work_solid: assert property (s_held ##0 (!hi && req.working && !work_disable)
        |-> led == 2'h2)
        else $error("working led wrong");
    a_work_dark: assert property (s_held ##0 (!hi && req.working && work_disable)
        |-> led == 2'h0)
        else $error("disabled working led lit");
    a_stby_alt: assert property (s_held ##0 (!hi && !req.working && req.standby)
        |-> led == 2'h1)
        else $error("standby led wrong");
    a_ready_on: assert property (s_held ##0 (!hi && req[5:4] == 2'h0 && req.ready_mode)
        |-> led == 2'h2)
        else $error("ready led wrong");
endmodule

// ---- pled_plat.sv ----
/* pled_plat: platform side, random requests and settings.
   assumes the bench seeds $urandom; drives on falling edges. */
`timescale 1ns/1ps
module pled_plat
    import pled_pkg::*;
(
    // clock and enable
    input  wire logic clk_sys,
    input  wire logic go,
    // platform outputs
    output pled_req_t req,
    output logic      post_err,
    output logic      work_disable,
    output logic      stby_alt_sel
);
    logic [1:0] ph;
    initial {req, post_err, work_disable, stby_alt_sel, ph} = '0;
    // new state every 4 cycles; shift thins out high-priority requests
    always @(negedge clk_sys)
    begin
        ph <= ph + 2'h1;
        if (go && ph == 2'h3)
        begin
            req <= 6'($urandom) << $urandom_range(4, 0);
            post_err <= ($urandom_range(7, 0) == 0);
            {work_disable, stby_alt_sel} <= 2'($urandom);
        end
    end
endmodule

// ---- power_led_blink_patterns_tb.sv ----
/* power_led_blink_patterns_tb: random requests against a priority model.
   assumes tick far beyond the run, so first-phase levels are checked. */
`timescale 1ns/1ps
module power_led_blink_patterns_tb import pled_pkg::*;;
    logic       clk_sys;
    logic       rst;
    logic       go;
    pled_req_t  req;
    logic       post_err;
    logic       work_disable;
    logic       stby_alt_sel;
    pled_led_t  led;
    logic [8:0] prv;
    logic [1:0] exp_led;
    int         held;
    int         error_cnt = 0;
    int         samples_checked = 0;
    int         cyc = 0;
    pled_top u_dut (.clk_sys(clk_sys), .rst(rst), .req(req), .post_err(post_err),
        .work_disable(work_disable), .stby_alt_sel(stby_alt_sel), .led(led));
    pled_plat u_plat (.clk_sys(clk_sys), .go(go), .req(req), .post_err(post_err),
        .work_disable(work_disable), .stby_alt_sel(stby_alt_sel));
    function automatic logic [1:0] model(pled_req_t r, logic pe, logic wd);
        if (r.mem_error || pe) return 2'h2;
        if (r.therm_trip) return 2'h2;
        if (r.fw_update) return 2'h0;
        if (r.working) return wd ? 2'h0 : 2'h2;
        if (r.standby) return 2'h1;
        return r.ready_mode ? 2'h2 : 2'h0;
    endfunction
    task check(string nm, logic [1:0] seen, logic [1:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task close_out;
        $display("checked %0d errors %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    initial
    begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            error_cnt++;
            close_out();
        end
    end
    initial
    begin
        rst = 1'b1;
        go = 1'b0;
        prv = '0;
        held = 0;
        void'($urandom(32'h483E));
        repeat (3) @(negedge clk_sys);
        check("reset", led, 2'h0);
        rst <= 1'b0;
        go <= 1'b1;
        repeat (1600)
        begin
            @(posedge clk_sys);
            held = ({req, post_err, work_disable, stby_alt_sel} == prv) ? held + 1 : 0;
            prv = {req, post_err, work_disable, stby_alt_sel};
            #1;
            exp_led = model(req, post_err, work_disable);
            if (held >= 2)
                check("led", led, exp_led);
        end
        close_out();
    end
endmodule
bind pled_top pled_top_sva u_sva (.clk_sys(clk_sys), .rst(rst), .req(req),
    .post_err(post_err), .work_disable(work_disable), .stby_alt_sel(stby_alt_sel), .led(led));
